// File: rtl/pmc_pkg.sv
// Constants for the power management configuration registers.
// Assumes byte offsets from configuration space and 32-bit data.
package pmc_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  CAP_OFS       = 8'hC0;
	localparam logic [7:0]  CSR_OFS       = 8'hC4;
	localparam logic [7:0]  CAP_IDENT     = 8'h01;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int          D3C_BIT       = 31;
	localparam int          WAKE_FLAG_BIT = 15;
	localparam int          DSCALE_LSB    = 13;
	localparam int          DATA_SELECT_FIELD_LSB      = 9;
	localparam int          DATA_SELECT_FIELD_W        = 4;
	localparam int          WAKE_EN_BIT   = 8;
	localparam int          PSTATE_LSB    = 0;

	// ************************************************************
	// Reset values and supported states
	// ************************************************************
	localparam logic [1:0]  DSCALE_VAL    = 2'h0;
	localparam logic [3:0]  DATA_SELECT_FIELD_RST      = 4'h0;
	localparam logic [3:0]  PSTATE_OK     = 4'hF;

	typedef enum logic [1:0]
	{
		PMC_D0    = 2'h0,
		PMC_D1    = 2'h1,
		PMC_D2    = 2'h2,
		PMC_D3HOT = 2'h3
	} pmc_pstate_t;

endpackage

// File: rtl/pmc_sync.sv
// Three-stage synchroniser for a pin level.
// Assumes one clock; the output moves only when stages two and three agree.
`timescale 1ns/1ps

module pmc_sync
(
	input  wire logic ref_clk,
	input  wire logic pin_in,
	output logic      level_out
);
	typedef struct packed
	{
		logic [2:0] stage;
		logic       level;
	} pmc_sync_t;

	pmc_sync_t st_r;
	pmc_sync_t st_nxt;

	always_comb
	begin
		st_nxt       = st_r;
		st_nxt.stage = {st_r.stage[1:0], pin_in};
		// Stage zero feeds only stage one
		if (st_r.stage[1] == st_r.stage[2])
			st_nxt.level = st_r.stage[2];
	end

	// No reset: the level is captured while reset is held, so the stages must keep sampling
	always_ff @(posedge ref_clk)
	begin
		st_r <= st_nxt;
	end

	assign level_out = st_r.level;
endmodule

// File: rtl/pmc_csr.sv
// Power management capability and control/status registers.
// Assumes configuration accesses as one-cycle strobes on ref_clk.
`timescale 1ns/1ps

module pmc_csr
(
	input  wire logic                         ref_clk,
	input  wire logic                         reset,
	input  wire logic                         power_on_reset,
	input  wire logic                         nv_d3cold_support,
	input  wire logic                         aux_power_detect,
	input  wire logic                         wake_event,
	input  wire logic                         cfg_rd,
	input  wire logic                         cfg_wr,
	input  wire logic [pmc_pkg::ADDR_W-1:0]   cfg_addr,
	input  wire logic [3:0]                   cfg_be,
	input  wire logic [31:0]                  cfg_wdata,
	output logic      [31:0]                  cfg_rdata,
	output logic                              cfg_rvalid,
	output logic      [1:0]                   power_state,
	output logic                              pme_n_o,
	output logic                              pme_n_oe_n
);
	import pmc_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed
	{
		logic              d3cold_wake_support;
		logic              wake_status_flag;
		logic              wake_assert_enable;
		logic [DATA_SELECT_FIELD_W-1:0] data_select_field;
		pmc_pstate_t       power_state_field;
		logic [31:0]       rdata;
		logic              rvalid;
		logic              pme_oe_n;
	} pmc_csr_t;

	pmc_csr_t st_r;
	pmc_csr_t st_nxt;
	logic     aux_level;

	pmc_sync u_aux_sync
	(
		.ref_clk   (ref_clk),
		.pin_in    (aux_power_detect),
		.level_out (aux_level)
	);

	function automatic logic [31:0] csr_word(input pmc_csr_t s);
		logic [31:0] w;
		w                                  = '0;
		w[WAKE_FLAG_BIT]                   = s.wake_status_flag;
		w[DSCALE_LSB +: 2]                 = DSCALE_VAL;
		w[DATA_SELECT_FIELD_LSB +: DATA_SELECT_FIELD_W]              = s.data_select_field;
		w[WAKE_EN_BIT]                     = s.wake_assert_enable;
		w[PSTATE_LSB +: 2]                 = s.power_state_field;
		return w;
	endfunction

	logic csr_wr;
	logic cap_rd;
	logic csr_rd;

	assign csr_wr = cfg_wr && (cfg_addr == CSR_OFS);
	assign cap_rd = cfg_rd && (cfg_addr == CAP_OFS);
	assign csr_rd = cfg_rd && (cfg_addr == CSR_OFS);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.rvalid = cfg_rd;
		if (reset)
		begin
			// Aux power absent forces D3cold wake support off
			st_nxt.d3cold_wake_support = nv_d3cold_support && aux_level;
			st_nxt.data_select_field   = DATA_SELECT_FIELD_RST;
			st_nxt.power_state_field   = PMC_D0;
			st_nxt.rdata               = '0;
			st_nxt.rvalid              = 1'b0;
			if (power_on_reset || !st_nxt.d3cold_wake_support)
			begin
				st_nxt.wake_status_flag   = 1'b0;
				st_nxt.wake_assert_enable = 1'b0;
			end
		end
		else
		begin
			if (csr_wr && cfg_be[1])
			begin
				if (cfg_wdata[WAKE_FLAG_BIT])
					st_nxt.wake_status_flag = 1'b0;
				st_nxt.data_select_field  = cfg_wdata[DATA_SELECT_FIELD_LSB +: DATA_SELECT_FIELD_W];
			end
			if (csr_wr && cfg_be[1])
				st_nxt.wake_assert_enable = cfg_wdata[WAKE_EN_BIT];
			// Set after clear so an event in the clear cycle survives
			if (wake_event)
				st_nxt.wake_status_flag = 1'b1;
			if (csr_wr && cfg_be[0] && PSTATE_OK[cfg_wdata[PSTATE_LSB +: 2]])
				st_nxt.power_state_field = pmc_pstate_t'(cfg_wdata[PSTATE_LSB +: 2]);
			if (cap_rd)
			begin
				st_nxt.rdata          = '0;
				st_nxt.rdata[7:0]     = CAP_IDENT;
				st_nxt.rdata[D3C_BIT] = st_r.d3cold_wake_support;
			end
			else if (csr_rd)
				st_nxt.rdata = csr_word(st_r);
			else if (cfg_rd)
				st_nxt.rdata = '0;
		end
		// Open-drain: enable low means the pin is pulled low
		st_nxt.pme_oe_n = !(st_nxt.wake_status_flag && st_nxt.wake_assert_enable);
	end

	// Power-on reset always arrives together with reset
	always_ff @(posedge ref_clk)
	begin
		st_r <= st_nxt;
	end

	assign cfg_rdata   = st_r.rdata;
	assign cfg_rvalid  = st_r.rvalid;
	assign power_state = st_r.power_state_field;
	assign pme_n_o     = 1'b0;
	assign pme_n_oe_n  = st_r.pme_oe_n;

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_cap_ident;
		@(posedge ref_clk) disable iff (reset)
		cap_rd |=> cfg_rvalid && (cfg_rdata[7:0] == CAP_IDENT);
	endproperty
	a_cap_ident: assert property (p_cap_ident) else $error("capability id wrong");

	property p_wake_set;
		@(posedge ref_clk) disable iff (reset)
		wake_event |=> st_r.wake_status_flag;
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("wake event lost");

	property p_wake_clear;
		@(posedge ref_clk) disable iff (reset)
		csr_wr && cfg_be[1] && cfg_wdata[WAKE_FLAG_BIT] && !wake_event |=> !st_r.wake_status_flag;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake flag not cleared");

	property p_por_flag;
		@(posedge ref_clk)
		reset && power_on_reset |=> !st_r.wake_status_flag && !st_r.wake_assert_enable;
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("power-up did not clear wake state");

	property p_dscale;
		@(posedge ref_clk) disable iff (reset)
		csr_rd |=> cfg_rdata[DSCALE_LSB +: 2] == DSCALE_VAL;
	endproperty
	a_dscale: assert property (p_dscale) else $error("data scale nonzero");

	property p_data_select_field;
		@(posedge ref_clk) disable iff (reset)
		csr_wr && cfg_be[1] |=> st_r.data_select_field == $past(cfg_wdata[DATA_SELECT_FIELD_LSB +: DATA_SELECT_FIELD_W]);
	endproperty
	a_data_select_field: assert property (p_data_select_field) else $error("data select not written");

	property p_pme_gate;
		@(posedge ref_clk) disable iff (reset)
		csr_wr && cfg_be[1] && !cfg_wdata[WAKE_EN_BIT] |=> pme_n_oe_n;
	endproperty
	a_pme_gate: assert property (p_pme_gate) else $error("wake pin driven without cause");

	property p_pme_follow;
		@(posedge ref_clk) disable iff (reset)
		wake_event && st_r.wake_assert_enable && !csr_wr |=> !pme_n_oe_n;
	endproperty
	a_pme_follow: assert property (p_pme_follow) else $error("wake pin not driven");

	property p_pstate;
		@(posedge ref_clk) disable iff (reset)
		csr_wr && cfg_be[0] |=> power_state ==
			(PSTATE_OK[$past(cfg_wdata[1:0])] ? $past(cfg_wdata[1:0]) : $past(power_state));
	endproperty
	a_pstate: assert property (p_pstate) else $error("power state write wrong");

	property p_d3c;
		@(posedge ref_clk) disable iff (reset)
		$fell(reset) |-> st_r.d3cold_wake_support == ($past(nv_d3cold_support) && $past(aux_level));
	endproperty
	a_d3c: assert property (p_d3c) else $error("D3cold support not captured");
endmodule

// File: verif/pmc_host_model.sv
// Host model issuing configuration reads and writes.
// Assumes the block answers a read within four cycles of the strobe.
`timescale 1ns/1ps

module pmc_host_model
(
	input  wire logic                       ref_clk,
	output logic                            cfg_rd,
	output logic                            cfg_wr,
	output logic      [pmc_pkg::ADDR_W-1:0] cfg_addr,
	output logic      [3:0]                 cfg_be,
	output logic      [31:0]                cfg_wdata,
	input  wire logic [31:0]                cfg_rdata,
	input  wire logic                       cfg_rvalid
);
	import pmc_pkg::*;

	initial
	begin
		cfg_rd    = 1'b0;
		cfg_wr    = 1'b0;
		cfg_addr  = 8'h00;
		cfg_be    = 4'h0;
		cfg_wdata = 32'h0;
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge ref_clk);
		cfg_wr    <= 1'b1;
		cfg_addr  <= a;
		cfg_be    <= be;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr    <= 1'b0;
		// Stale data never looks valid
		cfg_wdata <= ~d;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic ok);
		ok = 1'b0;
		d  = 32'h0;
		@(posedge ref_clk);
		cfg_rd   <= 1'b1;
		cfg_addr <= a;
		@(posedge ref_clk);
		cfg_rd   <= 1'b0;
		for (int i = 0; i < 4 && !ok; i++)
		begin
			#1;
			if (cfg_rvalid === 1'b1)
			begin
				d  = cfg_rdata;
				ok = 1'b1;
			end
			else
				@(posedge ref_clk);
		end
	endtask
endmodule

// File: verif/tb_top.sv
// Testbench for the power management registers.
// Assumes the host model drives every configuration access.
`timescale 1ns/1ps

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %0t got %h exp %h", $time, g, e); end end

module tb_top;
	import pmc_pkg::*;
	logic              ref_clk = 1'b0;
	logic              reset = 1'b1;
	logic              power_on_reset = 1'b1;
	logic              nv_d3cold_support = 1'b1;
	logic              aux_power_detect = 1'b1;
	logic              wake_event = 1'b0;
	logic              cfg_rd, cfg_wr, cfg_rvalid;
	logic [ADDR_W-1:0] cfg_addr;
	logic [3:0]        cfg_be;
	logic [31:0]       cfg_wdata, cfg_rdata;
	logic [1:0]        power_state;
	logic              pme_n_o, pme_n_oe_n;
	int                error_cnt = 0;
	int                checks_done = 0;

	pmc_csr i_pmc_csr (.ref_clk(ref_clk), .reset(reset), .power_on_reset(power_on_reset),
		.nv_d3cold_support(nv_d3cold_support), .aux_power_detect(aux_power_detect),
		.wake_event(wake_event), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.power_state(power_state), .pme_n_o(pme_n_o), .pme_n_oe_n(pme_n_oe_n));
	pmc_host_model i_pmc_host_model (.ref_clk(ref_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid));

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic        ok;
		i_pmc_host_model.rd(a, d, ok);
		if (!ok)
		begin
			error_cnt++;
			$display("mismatch %0t read timeout", $time);
			summarize();
		end
		else
			`CHK(d, e)
	endtask

	task automatic wrc(input logic [31:0] d);
		i_pmc_host_model.wr(CSR_OFS, 4'h3, d);
		#1;
	endtask

	// Reset held 16 cycles; aux sampled well settled
	task automatic rst(input logic por, input logic nv, input logic aux);
		@(posedge ref_clk);
		reset             <= 1'b1;
		power_on_reset    <= por;
		nv_d3cold_support <= nv;
		aux_power_detect  <= aux;
		repeat (16) @(posedge ref_clk);
		reset          <= 1'b0;
		power_on_reset <= 1'b0;
	endtask

	task automatic t_fields();
		rdc(CAP_OFS, 32'h8000_0001);
		rdc(CSR_OFS, 32'h0);
		rdc(8'h10, 32'h0);
		wrc(32'h0000_7F02);
		rdc(CSR_OFS, 32'h0000_1F02);
		for (int i = 0; i < 4; i++)
		begin
			wrc(32'h0000_1F00 | i);
			`CHK(power_state, 2'(i))
		end
		`CHK(pme_n_o, 1'b0)
		$display("test fields done");
	endtask

	task automatic t_wake();
		wrc(32'h0);
		@(posedge ref_clk);
		wake_event <= 1'b1;
		@(posedge ref_clk);
		wake_event <= 1'b0;
		#1;
		`CHK(pme_n_oe_n, 1'b1)
		rdc(CSR_OFS, 32'h0000_8000);
		wrc(32'h0000_0100);
		`CHK(pme_n_oe_n, 1'b0)
		rdc(CSR_OFS, 32'h0000_8100);
		wrc(32'h0000_8100);
		`CHK(pme_n_oe_n, 1'b1)
		rdc(CSR_OFS, 32'h0000_0100);
		@(posedge ref_clk);
		wake_event <= 1'b1;
		@(posedge ref_clk);
		wake_event <= 1'b0;
		#1;
		`CHK(pme_n_oe_n, 1'b0)
		$display("test wake done");
	endtask

	task automatic t_keep();
		rst(1'b0, 1'b1, 1'b1);
		rdc(CSR_OFS, 32'h0000_8100);
		`CHK(pme_n_oe_n, 1'b0)
		rst(1'b0, 1'b1, 1'b0);
		rdc(CAP_OFS, 32'h0000_0001);
		rdc(CSR_OFS, 32'h0);
		`CHK(pme_n_oe_n, 1'b1)
		$display("test keep done");
	endtask

	initial
	begin
		rst(1'b1, 1'b1, 1'b1);
		t_fields();
		t_wake();
		t_keep();
		summarize();
	end
endmodule
